// *** shared/pdc_defs.svh ***
// Register map, field positions and reset values of the profile two divider bank.
// Assumes inclusion by the package and the register module only.
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ****************************************************************************
// Register indices and address width
// ****************************************************************************
`define PDC_IDX_FRAC_HIGH     6'h11
`define PDC_IDX_NUM_LOW       6'h12
`define PDC_IDX_DEN_LOW       6'h13
`define PDC_IDX_N_CTRL        6'h14
`define PDC_IDX_REF_DIV       6'h15
`define PDC_IDX_FILT_MULT     6'h16
`define PDC_IDX_MODE          6'h30
`define PDC_IDX_STATUS        6'h31
`define PDC_ADDR_W            8

// ****************************************************************************
// Reset values
// ****************************************************************************
`define PDC_RST_FRAC_HIGH     16'h0000
`define PDC_RST_NUM_LOW       16'h0000
`define PDC_RST_DEN_LOW       16'h0000
`define PDC_RST_N_CTRL        16'h0028
`define PDC_RST_REF_DIV       16'h0101
`define PDC_RST_FILT_MULT     16'h8584
`define PDC_RST_MODE          2'h0

// ****************************************************************************
// Field positions, limits and bus response codes
// ****************************************************************************
`define PDC_F_RES3            15:13
`define PDC_F_CHDIV2          12:10
`define PDC_F_CHDIV1          9:8
`define PDC_F_DELAY           7:5
`define PDC_F_MULT            4:0
`define PDC_F_POST_DIV        15:8
`define PDC_F_PRE_DIV         7:0
`define PDC_B_PRESCALE        15
`define PDC_F_ORDER           14:12
`define PDC_F_N_INT           11:0
`define PDC_F_DEN_HIGH        15:8
`define PDC_F_NUM_HIGH        7:0
`define PDC_B_EXT_OSC         0
`define PDC_B_SHIFT_KEY       1
`define PDC_N_MAX             12'h3FF
`define PDC_N_FRAC_SPLIT      12'h016
`define PDC_MULT_BYPASS       5'h01
`define PDC_MULT_MAX          5'h0D
`define PDC_ORDER_MAX         3'h4
`define PDC_CHDIV2_MAX        3'h6
`define PDC_CHDIV1_BASE       3'h4
`define PDC_DELAY_INT_MAX     3'h5
`define PDC_DELAY_LOWN_MAX    3'h4
`define PDC_DELAY_HIGHN_MIN   3'h3
`define PDC_RESP_OKAY         2'h0
`define PDC_RESP_SLVERR       2'h2

`endif

// *** shared/pdc_pkg.sv ***
// Types shared by the profile two divider bank and its bench.
// Assumes the defines header sits on the include path.
`include "pdc_defs.svh"

package pdc_pkg;

   // *************************************************************************
   // Decoded configuration carried to the synthesizer core
   // *************************************************************************
   typedef struct packed {
      logic [23:0] frac_num;
      logic [23:0] frac_den;
      logic [11:0] n_int;
      logic        prescale_by4;
      logic [2:0]  order;
      logic        integer_mode;
      logic [4:0]  mult;
      logic        mult_bypass;
      logic [7:0]  pre_div;
      logic [7:0]  post_div;
      logic [6:0]  chdiv2_ratio;
      logic [2:0]  chdiv1_ratio;
      logic [2:0]  delay;
      logic [2:0]  res3_code;
      logic        res3_bypass;
      logic        pll_mode;
      logic        fsk_en;
   } pdc_cfg_t;

   // *************************************************************************
   // Live check flags shown in the status register
   // *************************************************************************
   typedef struct packed {
      logic fsk_den_nonzero;
      logic delay_advice;
      logic pre_not_below_mult;
      logic mult_reserved;
      logic n_over_limit;
   } pdc_stat_t;

endpackage

// *** src/pdc_regs.sv ***
// Profile two divider configuration bank with an AXI4-Lite register slave.
// Assumes one 10 MHz clock, a synchronous active-low reset and a single master.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pdc_defs.svh"

module pdc_regs
   import pdc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output      pdc_cfg_t    cfg,
   output      pdc_stat_t   stat
);

   // *************************************************************************
   // Helpers
   // *************************************************************************
   function automatic logic [5:0] word_idx(input logic [7:0] addr);
      word_idx = addr[7:2];
   endfunction

   function automatic logic mapped(input logic [5:0] idx);
      mapped = (idx >= `PDC_IDX_FRAC_HIGH && idx <= `PDC_IDX_FILT_MULT) ||
               idx == `PDC_IDX_MODE || idx == `PDC_IDX_STATUS;
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // *************************************************************************
   // Bus handshake state
   // *************************************************************************
   logic        aw_held_r,  aw_held_nxt;
   logic        w_held_r,   w_held_nxt;
   logic [7:0]  awaddr_r,   awaddr_nxt;
   logic [31:0] wdata_r,    wdata_nxt;
   logic [3:0]  wstrb_r,    wstrb_nxt;
   logic        awready_r,  awready_nxt;
   logic        wready_r,   wready_nxt;
   logic        bvalid_r,   bvalid_nxt;
   logic [1:0]  bresp_r,    bresp_nxt;
   logic        arready_r,  arready_nxt;
   logic        rvalid_r,   rvalid_nxt;
   logic [1:0]  rresp_r,    rresp_nxt;
   logic [31:0] rdata_r,    rdata_nxt;
   logic        do_write;
   logic [5:0]  wr_idx;

   // *************************************************************************
   // Register contents
   // *************************************************************************
   logic [15:0] frac_high_r, frac_high_nxt;
   logic [15:0] num_low_r,   num_low_nxt;
   logic [15:0] den_low_r,   den_low_nxt;
   logic [15:0] n_ctrl_r,    n_ctrl_nxt;
   logic [15:0] ref_div_r,   ref_div_nxt;
   logic [15:0] filt_mult_r, filt_mult_nxt;
   logic [1:0]  mode_r,      mode_nxt;
   pdc_cfg_t    cfg_r,       cfg_nxt;
   pdc_stat_t   stat_r,      stat_nxt;

   assign wr_idx   = word_idx(awaddr_r);
   assign do_write = aw_held_r && w_held_r && !bvalid_r;

   // *************************************************************************
   // Write channel
   // *************************************************************************
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt  = w_held_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      if (s_axi_awvalid && awready_r) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_held_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
         wstrb_nxt  = s_axi_wstrb;
      end
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = (mapped(wr_idx) && wr_idx != `PDC_IDX_STATUS) ?
                       `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt  = !w_held_nxt && !bvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `PDC_RESP_OKAY;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r  <= w_held_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
      end
   end

   // *************************************************************************
   // Register file
   // *************************************************************************
   always_comb begin
      frac_high_nxt = frac_high_r;
      num_low_nxt   = num_low_r;
      den_low_nxt   = den_low_r;
      n_ctrl_nxt    = n_ctrl_r;
      ref_div_nxt   = ref_div_r;
      filt_mult_nxt = filt_mult_r;
      mode_nxt      = mode_r;
      if (do_write) begin
         case (wr_idx)
            `PDC_IDX_FRAC_HIGH: frac_high_nxt = merge(frac_high_r, wdata_r, wstrb_r);
            `PDC_IDX_NUM_LOW:   num_low_nxt   = merge(num_low_r, wdata_r, wstrb_r);
            `PDC_IDX_DEN_LOW:   den_low_nxt   = merge(den_low_r, wdata_r, wstrb_r);
            `PDC_IDX_N_CTRL:    n_ctrl_nxt    = merge(n_ctrl_r, wdata_r, wstrb_r);
            `PDC_IDX_REF_DIV:   ref_div_nxt   = merge(ref_div_r, wdata_r, wstrb_r);
            `PDC_IDX_FILT_MULT: filt_mult_nxt = merge(filt_mult_r, wdata_r, wstrb_r);
            `PDC_IDX_MODE: begin
               if (wstrb_r[0]) begin
                  mode_nxt = wdata_r[1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frac_high_r <= `PDC_RST_FRAC_HIGH;
         num_low_r   <= `PDC_RST_NUM_LOW;
         den_low_r   <= `PDC_RST_DEN_LOW;
         n_ctrl_r    <= `PDC_RST_N_CTRL;
         ref_div_r   <= `PDC_RST_REF_DIV;
         filt_mult_r <= `PDC_RST_FILT_MULT;
         mode_r      <= `PDC_RST_MODE;
      end else begin
         frac_high_r <= frac_high_nxt;
         num_low_r   <= num_low_nxt;
         den_low_r   <= den_low_nxt;
         n_ctrl_r    <= n_ctrl_nxt;
         ref_div_r   <= ref_div_nxt;
         filt_mult_r <= filt_mult_nxt;
         mode_r      <= mode_nxt;
      end
   end

   // *************************************************************************
   // Configuration decode and live checks
   // *************************************************************************
   always_comb begin
      logic [2:0] ch2;
      logic [2:0] dly;
      logic [4:0] mul;
      logic [11:0] nint;
      ch2  = filt_mult_r[`PDC_F_CHDIV2];
      dly  = filt_mult_r[`PDC_F_DELAY];
      mul  = filt_mult_r[`PDC_F_MULT];
      nint = n_ctrl_r[`PDC_F_N_INT];
      cfg_nxt.frac_num     = {frac_high_r[`PDC_F_NUM_HIGH], num_low_r};
      cfg_nxt.frac_den     = {frac_high_r[`PDC_F_DEN_HIGH], den_low_r};
      cfg_nxt.n_int        = nint;
      cfg_nxt.prescale_by4 = n_ctrl_r[`PDC_B_PRESCALE];
      cfg_nxt.order        = n_ctrl_r[14] ? `PDC_ORDER_MAX : n_ctrl_r[`PDC_F_ORDER];
      cfg_nxt.integer_mode = n_ctrl_r[`PDC_F_ORDER] == 3'h0;
      cfg_nxt.mult         = mul;
      cfg_nxt.mult_bypass  = mul == `PDC_MULT_BYPASS;
      cfg_nxt.pre_div      = ref_div_r[`PDC_F_PRE_DIV];
      cfg_nxt.post_div     = ref_div_r[`PDC_F_POST_DIV];
      cfg_nxt.chdiv2_ratio = 7'h00;
      cfg_nxt.chdiv1_ratio = 3'h0;
      if (!mode_r[`PDC_B_EXT_OSC]) begin
         if (ch2 <= `PDC_CHDIV2_MAX) begin
            cfg_nxt.chdiv2_ratio = 7'h01 << ch2;
         end
         cfg_nxt.chdiv1_ratio = `PDC_CHDIV1_BASE + {1'b0, filt_mult_r[`PDC_F_CHDIV1]};
      end
      cfg_nxt.delay        = dly;
      cfg_nxt.res3_code    = filt_mult_r[`PDC_F_RES3];
      cfg_nxt.res3_bypass  = filt_mult_r[`PDC_F_RES3] == 3'h0;
      cfg_nxt.pll_mode     = mode_r[`PDC_B_EXT_OSC];
      cfg_nxt.fsk_en       = mode_r[`PDC_B_SHIFT_KEY];
      stat_nxt.n_over_limit       = nint > `PDC_N_MAX;
      stat_nxt.mult_reserved      = mul == 5'h00 || mul > `PDC_MULT_MAX;
      stat_nxt.pre_not_below_mult = ref_div_r[`PDC_F_PRE_DIV] >= {3'h0, mul};
      if (n_ctrl_r[`PDC_F_ORDER] == 3'h0) begin
         stat_nxt.delay_advice = dly > `PDC_DELAY_INT_MAX;
      end else if (nint < `PDC_N_FRAC_SPLIT) begin
         stat_nxt.delay_advice = dly > `PDC_DELAY_LOWN_MAX;
      end else begin
         stat_nxt.delay_advice = dly < `PDC_DELAY_HIGHN_MIN;
      end
      stat_nxt.fsk_den_nonzero = mode_r[`PDC_B_SHIFT_KEY] &&
                                 {frac_high_r[`PDC_F_DEN_HIGH], den_low_r} != 24'h000000;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r  <= '0;
         stat_r <= '0;
      end else begin
         cfg_r  <= cfg_nxt;
         stat_r <= stat_nxt;
      end
   end

   // *************************************************************************
   // Read channel
   // *************************************************************************
   always_comb begin
      logic [5:0] idx;
      idx         = word_idx(s_axi_araddr);
      arready_nxt = arready_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (s_axi_arvalid && arready_r) begin
         arready_nxt = 1'b0;
         rvalid_nxt  = 1'b1;
         rresp_nxt   = mapped(idx) ? `PDC_RESP_OKAY : `PDC_RESP_SLVERR;
         case (idx)
            `PDC_IDX_FRAC_HIGH: rdata_nxt = {16'h0000, frac_high_r};
            `PDC_IDX_NUM_LOW:   rdata_nxt = {16'h0000, num_low_r};
            `PDC_IDX_DEN_LOW:   rdata_nxt = {16'h0000, den_low_r};
            `PDC_IDX_N_CTRL:    rdata_nxt = {16'h0000, n_ctrl_r};
            `PDC_IDX_REF_DIV:   rdata_nxt = {16'h0000, ref_div_r};
            `PDC_IDX_FILT_MULT: rdata_nxt = {16'h0000, filt_mult_r};
            `PDC_IDX_MODE:      rdata_nxt = {30'h0000_0000, mode_r};
            `PDC_IDX_STATUS:    rdata_nxt = {27'h000_0000, stat_r};
            default:            rdata_nxt = 32'h0000_0000;
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt  = 1'b0;
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= `PDC_RESP_OKAY;
      end else begin
         arready_r <= arready_nxt | (!arready_r && !rvalid_r);
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign cfg           = cfg_r;
   assign stat          = stat_r;

   // *************************************************************************
   // Checks
   // *************************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_write_to(logic [5:0] idx);
      do_write && wr_idx == idx;
   endsequence

   sequence seq_cfg_settle;
      ##2 1'b1;
   endsequence

   AST_RESET_FILTER: assert property ($past(!aresetn) |-> filt_mult_r == `PDC_RST_FILT_MULT &&
      ref_div_r == `PDC_RST_REF_DIV && n_ctrl_r == `PDC_RST_N_CTRL)
      else $error("Profile registers missed their reset values.");
   AST_HOLD_N: assert property (!(do_write && wr_idx == `PDC_IDX_N_CTRL) |=> $stable(n_ctrl_r))
      else $error("N register changed without a write.");
   AST_RES3_FIELD: assert property (seq_write_to(`PDC_IDX_FILT_MULT) ##0 wstrb_r[1] ##0 seq_cfg_settle
      |-> cfg.res3_code == $past(wdata_r[15:13], 2))
      else $error("Third-pole resistor code not taken from the write.");
   AST_CHDIV2_PLL: assert property (mode_r[`PDC_B_EXT_OSC] |=> cfg.chdiv2_ratio == 7'h00 &&
      cfg.chdiv1_ratio == 3'h0)
      else $error("Channel dividers active in PLL mode.");
   AST_CHDIV2_RATIO: assert property (!mode_r[0] && filt_mult_r[12:10] == 3'h6 |=>
      cfg.chdiv2_ratio == 7'h40)
      else $error("Second channel divider code 6 is not 64.");
   AST_CHDIV1_RATIO: assert property (!mode_r[0] |=>
      cfg.chdiv1_ratio == 3'h4 + {1'b0, $past(filt_mult_r[9:8])})
      else $error("First channel divider ratio wrong.");
   AST_ORDER_CLAMP: assert property (n_ctrl_r[14:12] >= 3'h4 |=> cfg.order == 3'h4)
      else $error("Modulator order above four not clamped.");
   AST_PRESCALE: assert property (1'b1 |=> cfg.prescale_by4 == $past(n_ctrl_r[15]))
      else $error("Prescaler select does not follow the register.");
   AST_FRAC_NUM: assert property (1'b1 |=> cfg.frac_num == {$past(frac_high_r[7:0]),
      $past(num_low_r)} && cfg.frac_den[15:0] == $past(den_low_r))
      else $error("Fraction halves not joined correctly.");
   AST_N_LIMIT: assert property (n_ctrl_r[11:0] > 12'h3FF |=> stat.n_over_limit)
      else $error("N above limit not flagged.");
   AST_MULT_RES: assert property (filt_mult_r[4:0] > 5'h0D |=> stat.mult_reserved)
      else $error("Reserved multiplier code not flagged.");
   AST_WRITE_RESP: assert property (do_write |=> s_axi_bvalid)
      else $error("Write response missing one cycle after the write.");
   AST_POST_DIV: assert property (1'b1 |=> cfg.post_div == $past(ref_div_r[15:8]))
      else $error("Post-divider output does not follow the register.");

endmodule

// *** tb/pdc_regs_bench.sv ***
// Self-checking bench for the profile two divider bank.
// Assumes the package and the defines header are compiled before this file.
`timescale 1ns/1ps

module pdc_regs_bench
   import pdc_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pdc_row_t;

   logic        aclk, aresetn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   pdc_cfg_t    cfg;
   pdc_stat_t   stat;
   int          errors, cmp_count, cycles;

   // ************************************************************************
   // Write and read rows, then reset values
   // ************************************************************************
   pdc_row_t rows [7] = '{'{8'h48, 32'hFFFFA5C3, 32'h0000A5C3}, '{8'h4C, 32'h5A3C, 32'h5A3C},
      '{8'h44, 32'h1234, 32'h1234}, '{8'h50, 32'hF3FF, 32'hF3FF}, '{8'h54, 32'h0203, 32'h0203},
      '{8'h58, 32'h1A6D, 32'h1A6D}, '{8'hC0, 32'h0, 32'h0}};
   pdc_row_t rst_rows [6] = '{'{8'h48, 32'h0, 32'h0}, '{8'h4C, 32'h0, 32'h0},
      '{8'h44, 32'h0, 32'h0}, '{8'h50, 32'h0, 32'h28}, '{8'h54, 32'h0, 32'h101},
      '{8'h58, 32'h0, 32'h8584}};

   pdc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .cfg(cfg), .stat(stat));

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk("bresp", 32'(er), 32'(s_axi_bresp));
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
   endtask

   task end_of_test();
      if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 32'h7D0) begin
         errors++;
         end_of_test();
      end
   end

   // ************************************************************************
   // Main sequence
   // ************************************************************************
   initial begin
      {errors, cmp_count, cycles} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      aresetn = 1'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, 4'hF, 2'h0);
         rd(rows[i].a, rows[i].e, 2'h0);
      end
      chk("frac_num", 32'h34A5C3, 32'(cfg.frac_num));
      chk("frac_den", 32'h125A3C, 32'(cfg.frac_den));
      chk("n_ctrl", 32'hC3FF, {cfg.prescale_by4, cfg.order, cfg.n_int});
      chk("int_mode", 32'h0, 32'(cfg.integer_mode));
      chk("ref", 32'h0D0302, {cfg.mult, cfg.pre_div, cfg.post_div});
      chk("chdiv", 32'h206, {cfg.chdiv2_ratio, cfg.chdiv1_ratio});
      chk("res3", 32'h1, {cfg.res3_code, cfg.res3_bypass});
      chk("delay", 32'h3, 32'(cfg.delay));
      chk("stat", 32'h0, 32'(stat));
      wr(8'h50, 32'h0400, 4'h3, 2'h0);
      rd(8'hC4, 32'h1, 2'h0);
      wr(8'h58, 32'hFFFF0081, 4'h1, 2'h0);
      rd(8'h58, 32'h1A81, 2'h0);
      chk("mult_bypass", 32'h1, 32'(cfg.mult_bypass));
      rd(8'hC4, 32'h5, 2'h0);
      wr(8'h60, 32'h1, 4'hF, 2'h2);
      rd(8'h60, 32'h0, 2'h2);
      wr(8'hC4, 32'hFF, 4'hF, 2'h2);
      wr(8'hC0, 32'h3, 4'hF, 2'h0);
      repeat (2) @(posedge aclk);
      chk("pll_chdiv", 32'h400, {cfg.pll_mode, cfg.chdiv2_ratio, cfg.chdiv1_ratio});
      chk("fsk_den", 32'h1, 32'(stat.fsk_den_nonzero));
      aresetn <= 1'h0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      foreach (rst_rows[i]) rd(rst_rows[i].a, rst_rows[i].e, 2'h0);
      chk("rst_cfg", 32'h10828, {cfg.res3_code, cfg.mult, cfg.pll_mode, cfg.n_int[7:0]});
      chk("rst_int_mode", 32'h1, 32'(cfg.integer_mode));
      wr(8'h58, 32'h001F, 4'h1, 2'h0);
      rd(8'hC4, 32'h2, 2'h0);
      wr(8'h58, 32'h00E4, 4'h1, 2'h0);
      rd(8'hC4, 32'h8, 2'h0);
      end_of_test();
   end

endmodule
